// ---- include/eeprom_ctl_pkg.sv ----
// Constants and types for the serial configuration memory controller
package eeprom_ctl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h70;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h74;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h78;
  localparam logic [7:0] OFS_CFG_BASE    = 8'h80;  // Autoloaded words, read only
  localparam logic [7:0] CFG_SPAN        = 8'h20;  // Eight words of four bytes

  // Control/status field positions
  localparam int BIT_START   = 0;
  localparam int BIT_CMD     = 1;
  localparam int BIT_ERR     = 2;
  localparam int BIT_DONE    = 3;
  localparam int BIT_DIV_LO  = 4;
  localparam int BIT_DIS     = 6;
  localparam int BIT_FAST    = 7;
  localparam int BIT_BUSY    = 8;
  localparam int BIT_ADDR_LO = 9;
  localparam int BIT_DATA_LO = 16;

  // Interrupt status bits
  localparam int IRQ_CYCLE_DONE = 0;
  localparam int IRQ_ACK_ERR    = 1;
  localparam int IRQ_LOAD_DONE  = 2;
  localparam int IRQ_W          = 3;

  // Divider half periods in core clocks (divide by 2x this value)
  localparam logic [12:0] HALF_DIV_8192 = 13'h1000;
  localparam logic [12:0] HALF_DIV_4096 = 13'h0800;
  localparam logic [12:0] HALF_DIV_2048 = 13'h0400;
  localparam logic [12:0] HALF_DIV_256  = 13'h0080;
  localparam int          FAST_SHIFT    = 3;        // Eight times faster

  // Autoload geometry
  localparam int          CFG_WORDS     = 8;
  localparam logic [6:0]  CFG_LAST      = 7'h07;

  // Serial frame: opcode bits, address bits, data bits
  localparam logic [2:0]  OP_READ  = 3'h6;
  localparam logic [2:0]  OP_WRITE = 3'h5;
  localparam logic [5:0]  FRAME_RD = 6'h1a;  // 3 op + 7 addr + 16 data
  localparam logic [5:0]  FRAME_WR = 6'h1b;  // Plus one ack bit

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_MAN  = 2'b10,
    ST_WAIT = 2'b11
  } ctl_state_t;

endpackage

// ---- hw/eeprom_shifter.sv ----
// Serial bit engine for one memory word frame
`timescale 1ns/1ns
module eeprom_shifter (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Request
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [6:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [12:0] half,
  // Result
  output logic             done,
  output logic             nack,
  output logic [15:0]      rdata,
  // Serial pins
  output logic             sk,
  output logic             cs,
  output logic             dout,
  input  wire logic        din
);

  typedef struct packed {
    logic        active;
    logic        wr;
    logic [12:0] cnt;
    logic [5:0]  bitn;
    logic [25:0] sh;
    logic [15:0] rd;
    logic        sk;
    logic        done;
    logic        nack;
    logic [1:0]  din_s;
  } shf_t;

  shf_t s_r;
  shf_t s_nxt;
  logic [5:0] last;

  assign last = s_r.wr ? eeprom_ctl_pkg::FRAME_WR : eeprom_ctl_pkg::FRAME_RD;

  // Shift on falling edge of sk, sample on rising edge
  always_comb begin
    s_nxt       = s_r;
    s_nxt.done  = 1'b0;
    s_nxt.din_s = {s_r.din_s[0], din};  // Two-stage sync of the pin
    if (go && !s_r.active) begin
      s_nxt.active = 1'b1;
      s_nxt.wr     = wr;
      s_nxt.cnt    = half;
      s_nxt.bitn   = 6'h00;
      s_nxt.nack   = 1'b0;
      s_nxt.sk     = 1'b0;
      s_nxt.sh     = {wr ? eeprom_ctl_pkg::OP_WRITE : eeprom_ctl_pkg::OP_READ, addr, wdata};
    end else if (s_r.active) begin
      if (s_r.cnt > 13'h0001) begin
        s_nxt.cnt = s_r.cnt - 13'h0001;
      end else begin
        s_nxt.cnt = half;
        s_nxt.sk  = ~s_r.sk;
        if (!s_r.sk) begin
          // Rising edge: capture read bits, check the trailing ack
          s_nxt.rd = {s_r.rd[14:0], s_r.din_s[1]};
          if (s_r.wr && s_r.bitn == eeprom_ctl_pkg::FRAME_WR - 6'h01 && s_r.din_s[1]) begin
            s_nxt.nack = 1'b1;
          end
        end else begin
          s_nxt.sh   = {s_r.sh[24:0], 1'b0};
          s_nxt.bitn = s_r.bitn + 6'h01;
          if (s_r.bitn + 6'h01 == last) begin
            s_nxt.active = 1'b0;
            s_nxt.done   = 1'b1;
            s_nxt.sk     = 1'b0;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done  = s_r.done;
  assign nack  = s_r.nack;
  assign rdata = s_r.rd;
  assign sk    = s_r.sk;
  assign cs    = s_r.active;
  assign dout  = s_r.sh[25];

endmodule // eeprom_shifter

// ---- hw/eeprom_autoload_access.sv ----
// Configuration memory autoload and software access block with Wishbone slave
`timescale 1ns/1ns
module eeprom_autoload_access (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Interrupt
  output logic             IRQ,
  // Serial memory pins
  output logic             EE_SK,
  output logic             EE_CS,
  output logic             EE_DO,
  input  wire logic        EE_DI,
  // Loaded configuration words, flattened
  output logic [127:0]     CFG_WORDS_O
);

  ////////////////////////////////////////////////////////////////////////
  // State

  // One packed record holds every register of the block, so the next-state
  // logic starts from a full copy and changes only what it must.
  // Four sequencer states: a one-cycle decision after reset, the autoload
  // walk over the loaded words, one software cycle, and idle.
  // Busy is read straight from the state, so it can never disagree with it.
  // Software fields stay writable while a frame runs, except start, the command
  // and, during a software frame, the data lanes, which that frame is still using.
  // Divider select and fast bit may change at any time; the engine picks
  // the new half period up at its next serial clock edge, not at once.
  // Limitation: an autoload cannot be repeated without a reset.
  typedef struct packed {
    eeprom_ctl_pkg::ctl_state_t st;
    logic        start;
    logic        cmd;
    logic        err;
    logic        ld_ok;
    logic [1:0]  div;
    logic        dis;
    logic        fast;
    logic [6:0]  addr;
    logic [15:0] data;
    logic [6:0]  ld_idx;
    logic        ld_err;
    logic        go;
    logic [eeprom_ctl_pkg::IRQ_W-1:0] ist;
    logic [eeprom_ctl_pkg::IRQ_W-1:0] imask;
    logic        ack;
    logic [31:0] rdat;
    logic [eeprom_ctl_pkg::CFG_WORDS-1:0][15:0] cfg;  // Packed to keep the record packed
  } ctl_t;

  ctl_t c_r;
  ctl_t c_nxt;

  logic        sh_done;
  logic        sh_nack;
  logic [15:0] sh_rdata;
  logic [12:0] half;
  logic        wb_req;
  logic [eeprom_ctl_pkg::IRQ_W-1:0] ev;
  logic        loading;
  logic        manual;

  // Half period of the serial clock from the select
  function automatic logic [12:0] half_of(input logic [1:0] sel);
    case (sel)
      2'b00:   half_of = eeprom_ctl_pkg::HALF_DIV_8192;
      2'b01:   half_of = eeprom_ctl_pkg::HALF_DIV_4096;
      2'b10:   half_of = eeprom_ctl_pkg::HALF_DIV_2048;
      default: half_of = eeprom_ctl_pkg::HALF_DIV_256;
    endcase
  endfunction

  // Address falls inside the window of autoloaded words
  function automatic logic in_cfg(input logic [7:0] a);
    in_cfg = (a >= eeprom_ctl_pkg::OFS_CFG_BASE) &&
             (a < eeprom_ctl_pkg::OFS_CFG_BASE + eeprom_ctl_pkg::CFG_SPAN);
  endfunction

  // Read image of the control/status word, field by field
  function automatic logic [31:0] ctrl_word(input ctl_t c, input logic busy);
    logic [31:0] w;
    w                                     = 32'h0000_0000;
    w[eeprom_ctl_pkg::BIT_START]          = c.start;
    w[eeprom_ctl_pkg::BIT_CMD]            = c.cmd;
    w[eeprom_ctl_pkg::BIT_ERR]            = c.err;
    w[eeprom_ctl_pkg::BIT_DONE]           = c.ld_ok;
    w[eeprom_ctl_pkg::BIT_DIV_LO +: 2]    = c.div;
    w[eeprom_ctl_pkg::BIT_DIS]            = c.dis;
    w[eeprom_ctl_pkg::BIT_FAST]           = c.fast;
    w[eeprom_ctl_pkg::BIT_BUSY]           = busy;
    w[eeprom_ctl_pkg::BIT_ADDR_LO +: 7]   = c.addr;
    w[eeprom_ctl_pkg::BIT_DATA_LO +: 16]  = c.data;
    return w;
  endfunction

  // Sequencer state decode shared by the engine, divider and read mux
  assign loading = (c_r.st == eeprom_ctl_pkg::ST_LOAD);
  assign manual  = (c_r.st == eeprom_ctl_pkg::ST_MAN);

  // Fast mode only applies while autoloading; software cycles always use
  // the plain divider, so the select alone fixes their bit rate
  assign half = (loading && c_r.fast) ?
                (half_of(c_r.div) >> eeprom_ctl_pkg::FAST_SHIFT) :
                half_of(c_r.div);

  assign wb_req = WB_CYC_I && WB_STB_I && !c_r.ack;

  ////////////////////////////////////////////////////////////////////////
  // Serial engine

  // One engine serves both autoload and software cycles; the sequencer
  // never starts a frame while another runs, so no arbitration is needed.
  // The engine registers its own pin outputs, so select, clock and data
  // leave the block glitch free.
  // The returned pin passes two flip-flops inside the engine, which costs
  // two core clocks of the half period; the fastest half is sixteen clocks.
  // Write data is taken from the data field at the start of the frame.
  eeprom_shifter u_shf (
    .CLOCK (CLOCK),
    .RST   (RST),
    .go    (c_r.go),
    .wr    (manual && c_r.cmd),
    .addr  (loading ? c_r.ld_idx : c_r.addr),
    .wdata (c_r.data),
    .half  (half),
    .done  (sh_done),
    .nack  (sh_nack),
    .rdata (sh_rdata),
    .sk    (EE_SK),
    .cs    (EE_CS),
    .dout  (EE_DO),
    .din   (EE_DI)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control, sequencing and register access

  // Single next-state process: sequencer first, then bus access, so a
  // register write in the same cycle as a sequencer update sees the
  // sequencer's result, and interrupt events are merged last
  always_comb begin
    c_nxt      = c_r;
    c_nxt.go   = 1'b0;
    c_nxt.ack  = 1'b0;
    ev         = '0;

    // Sequencer
    case (c_r.st)
      // Idle: a pending start launches one software frame
      eeprom_ctl_pkg::ST_IDLE: begin
        if (c_r.start) begin
          c_nxt.err = 1'b0;
          c_nxt.go  = 1'b1;
          c_nxt.st  = eeprom_ctl_pkg::ST_MAN;
        end
      end
      // Autoload: store each word, then fetch the next one
      eeprom_ctl_pkg::ST_LOAD: begin
        if (sh_done) begin
          c_nxt.cfg[c_r.ld_idx[2:0]] = sh_rdata;
          if (c_r.ld_idx == eeprom_ctl_pkg::CFG_LAST) begin
            c_nxt.st    = eeprom_ctl_pkg::ST_IDLE;
            c_nxt.ld_ok = !c_r.ld_err;
            ev[eeprom_ctl_pkg::IRQ_LOAD_DONE] = 1'b1;
          end else begin
            c_nxt.ld_idx = c_r.ld_idx + 7'h01;
            c_nxt.go     = 1'b1;
          end
        end
      end
      // Software cycle: results land on the completion pulse
      eeprom_ctl_pkg::ST_MAN: begin
        if (sh_done) begin
          c_nxt.start = 1'b0;
          c_nxt.err   = sh_nack;
          if (!c_r.cmd) begin
            c_nxt.data = sh_rdata;
          end
          ev[eeprom_ctl_pkg::IRQ_CYCLE_DONE] = 1'b1;
          ev[eeprom_ctl_pkg::IRQ_ACK_ERR]    = sh_nack;
          c_nxt.st = eeprom_ctl_pkg::ST_IDLE;
        end
      end
      // Decision state, entered only from reset
      default: begin
        // Post-reset decision: autoload unless disabled
        if (!c_r.dis) begin
          c_nxt.st = eeprom_ctl_pkg::ST_LOAD;
          c_nxt.go = 1'b1;
        end else begin
          c_nxt.st = eeprom_ctl_pkg::ST_IDLE;
        end
      end
    endcase

    // Bus access, one wait state
    // A request is taken once; the registered ack blocks a second take
    // while the master still holds the request in the answer cycle.
    if (wb_req) begin
      c_nxt.ack  = 1'b1;
      c_nxt.rdat = 32'h0000_0000;  // Unmapped addresses read zero
      // Control/status word
      if (WB_ADR_I == eeprom_ctl_pkg::OFS_CTRL_STATUS) begin
        c_nxt.rdat = ctrl_word(c_r, loading);
        if (WB_WE_I) begin
          if (WB_SEL_I[0]) begin
            // Start only rises from zero and not during a running cycle
            if (WB_DAT_I[eeprom_ctl_pkg::BIT_START] && !c_r.start &&
                c_r.st == eeprom_ctl_pkg::ST_IDLE) begin
              c_nxt.start = 1'b1;
            end
            if (c_r.st == eeprom_ctl_pkg::ST_IDLE) begin
              c_nxt.cmd = WB_DAT_I[eeprom_ctl_pkg::BIT_CMD];
            end
            c_nxt.div  = WB_DAT_I[eeprom_ctl_pkg::BIT_DIV_LO +: 2];
            c_nxt.dis  = WB_DAT_I[eeprom_ctl_pkg::BIT_DIS];
            c_nxt.fast = WB_DAT_I[eeprom_ctl_pkg::BIT_FAST];
          end
          if (WB_SEL_I[1]) begin
            c_nxt.addr = WB_DAT_I[eeprom_ctl_pkg::BIT_ADDR_LO +: 7];
          end
          // Data lanes frozen during a software frame: the frame shifts the
          // value it started with, and a read overwrites the field at the end
          if (WB_SEL_I[2] && c_nxt.st != eeprom_ctl_pkg::ST_MAN) begin
            c_nxt.data[7:0] = WB_DAT_I[eeprom_ctl_pkg::BIT_DATA_LO +: 8];
          end
          if (WB_SEL_I[3] && c_nxt.st != eeprom_ctl_pkg::ST_MAN) begin
            c_nxt.data[15:8] = WB_DAT_I[eeprom_ctl_pkg::BIT_DATA_LO + 8 +: 8];
          end
        end
      // Interrupt status, cleared by a read
      end else if (WB_ADR_I == eeprom_ctl_pkg::OFS_IRQ_STATUS) begin
        c_nxt.rdat = {29'h0, c_r.ist};
        if (!WB_WE_I) begin
          c_nxt.ist = '0;  // Clear on read; new events below still win
        end
      // Interrupt mask, same layout as the status
      end else if (WB_ADR_I == eeprom_ctl_pkg::OFS_IRQ_MASK) begin
        c_nxt.rdat = {29'h0, c_r.imask};
        if (WB_WE_I && WB_SEL_I[0]) begin
          c_nxt.imask = WB_DAT_I[eeprom_ctl_pkg::IRQ_W-1:0];
        end
      // Loaded words, read only
      end else if (in_cfg(WB_ADR_I)) begin
        c_nxt.rdat = {16'h0000, c_r.cfg[WB_ADR_I[4:2]]};
      end
    end

    // Loader error accumulates across words, but autoload frames are reads
    // and the engine checks the ack only on writes, so the completion bit always sets
    if (loading && sh_done && sh_nack) begin
      c_nxt.ld_err = 1'b1;
    end

    // Sticky events, set wins over clear
    // Merged after the bus access so a read in the event cycle cannot
    // lose the event; it shows up at the next read instead
    c_nxt.ist = c_nxt.ist | ev;
  end

  // State register
  // Reset parks the sequencer in the decision state; autoload is chosen at
  // the first edge after release, from the reset value of the disable bit
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      c_r    <= '0;
      c_r.st <= eeprom_ctl_pkg::ST_WAIT;  // Autoload decision after release
    end else begin
      c_r <= c_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Ack and read data come from flip-flops; ack stands for one cycle, read data until the next request
  // Interrupt is a level from registers, high while an unmasked bit is set
  // so it stays clean of bus decode glitches
  assign WB_DAT_O = c_r.rdat;
  assign WB_ACK_O = c_r.ack;
  assign IRQ      = |(c_r.ist & c_r.imask);

  // Loaded words for the rest of the device
  // They keep their values until the next reset
  genvar gi;
  generate
    for (gi = 0; gi < eeprom_ctl_pkg::CFG_WORDS; gi++) begin : g_cfg
      assign CFG_WORDS_O[gi*16 +: 16] = c_r.cfg[gi];
    end
  endgenerate

endmodule // eeprom_autoload_access

// ---- tb/eeprom_access_properties.sv ----
// Port-level properties of the memory access block
`timescale 1ns/1ns
module eeprom_access_chk (
  // Clock and reset
  input wire logic         CLOCK,
  input wire logic         RST,
  // Bus
  input wire logic         WB_CYC_I,
  input wire logic         WB_STB_I,
  input wire logic         WB_WE_I,
  input wire logic [7:0]   WB_ADR_I,
  input wire logic [31:0]  WB_DAT_O,
  input wire logic         WB_ACK_O,
  // Serial pins and loaded words
  input wire logic         EE_SK,
  input wire logic         EE_CS,
  input wire logic         EE_DO,
  input wire logic [127:0] CFG_WORDS_O
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Request taken, then a one-cycle answer
  sequence req_s; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence answer_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
  bus_answer_a: assert property (req_s |=> answer_s)
    else $error("answer not one cycle after request");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  unmapped_zero_a: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I < 8'h70)
    |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  cfg_read_a: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 8'h84) |->
    WB_DAT_O[15:0] == CFG_WORDS_O[31:16]) else $error("loaded word read mismatch");
  // Data moves only while the serial clock is low
  do_settle_a: assert property ($changed(EE_DO) |-> !EE_SK)
    else $error("data changed with clock high");
  sk_frame_a: assert property ($rose(EE_SK) |-> EE_CS)
    else $error("serial clock outside frame");
  // Fastest half period is 16 core clocks
  sk_half_a: assert property ($rose(EE_SK) |=> EE_SK[*8])
    else $error("serial clock high too short");
  cs_hold_a: assert property ($rose(EE_CS) |=> EE_CS[*8])
    else $error("select pulse too short");
endmodule // eeprom_access_chk
bind eeprom_autoload_access eeprom_access_chk chk (.CLOCK, .RST, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .EE_SK, .EE_CS, .EE_DO, .CFG_WORDS_O);

// ---- tb/eeprom_model.sv ----
// Behavioural serial configuration memory
`timescale 1ns/1ns
module eeprom_model (
  // Clock
  input  wire logic clk,
  // Serial pins and fault control
  input  wire logic sk,
  input  wire logic cs,
  input  wire logic si,
  input  wire logic nack,
  output logic      so = 1'b0
);
  logic [15:0] mem [0:127];
  logic [4:0]  n = 5'h00;
  logic [9:0]  hdr = 10'h000;
  logic [15:0] sh = 16'h0000;
  logic        sk_q = 1'b0;
  // Word i holds c300 plus i
  initial begin
    for (int i = 0; i < 128; i++)
      mem[i] = 16'hc300 + 16'(i);
  end
  // Edge detect; line toggles when it is not answering
  always @(posedge clk) begin
    sk_q <= sk;
    if (!cs) begin
      n  <= 5'h00;
      so <= ~so;
    end else if (sk && !sk_q) begin
      n <= n + 5'h01;
      if (n < 5'h0a) hdr <= {hdr[8:0], si};
      else sh <= {sh[14:0], si};
      if (n == 5'h19 && hdr[9:7] == 3'h5) mem[hdr[6:0]] <= {sh[14:0], si};
    end else if (!sk && sk_q) begin
      if (hdr[9:7] == 3'h6 && n >= 5'h0a && n <= 5'h19) so <= mem[hdr[6:0]][5'h19 - n];
      else so <= (n == 5'h1a) ? nack : ~so;
    end
  end
endmodule // eeprom_model

// ---- tb/eeprom_autoload_access_tb_top.sv ----
// Self-checking bench for the autoload and access block
`timescale 1ns/1ns
module eeprom_autoload_access_tb_top;
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic         nack = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  rdat, q;
  logic [127:0] cfg;
  logic         ack, irq, sk, cs, dout, din;
  time          t0;
  int           mismatches = 0;
  int           checks_done = 0;
  // Core clock, 8 ns
  always #4 clock = ~clock;
  eeprom_autoload_access dut (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .IRQ(irq), .EE_SK(sk), .EE_CS(cs), .EE_DO(dout), .EE_DI(din),
    .CFG_WORDS_O(cfg));
  eeprom_model ee (.clk(clock), .sk(sk), .cs(cs), .si(dout), .nack(nack), .so(din));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until ack is seen on an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  // Polls the control word until the masked bits clear
  task automatic wait_clr(input logic [31:0] m);
    bus(1'b0, 8'h70, 32'h0);
    while ((q & m) !== 32'h0)
      bus(1'b0, 8'h70, 32'h0);
  endtask
  // Start word with fastest divider and fast load kept on
  function automatic logic [31:0] ctl(input logic c, input logic [6:0] a,
                                      input logic [15:0] d);
    return {d, a, 9'h0b0} | {30'h0, c, 1'b1};
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 8'h70, 32'h0);
    chk(q & 32'hffff_fefe, 32'h0);
    chk(q & 32'h100, 32'h100);
    bus(1'b1, 8'h70, 32'h0000_00b0);
    // First rise may still run out the slow count; later ones are fast
    repeat (2) @(posedge sk);
    t0 = $time;
    @(posedge sk);
    chk(32'(($time - t0) / 64'h8), 32'h20);
    wait_clr(32'h100);
    for (int i = 0; i < 8; i++)
      chk({16'h0, cfg[16*i +: 16]}, {16'h0, 16'hc300 + 16'(i)});
    chk(q & 32'h8, 32'h8);
    bus(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0000_c301);
    bus(1'b0, 8'h74, 32'h0);
    chk(q & 32'h4, 32'h4);
    bus(1'b1, 8'h60, 32'hffff_ffff);
    bus(1'b0, 8'h60, 32'h0);
    chk(q, 32'h0);
    // Manual write with events unmasked
    bus(1'b1, 8'h78, 32'h7);
    bus(1'b1, 8'h70, ctl(1'b1, 7'h05, 16'h1234));
    wait_clr(32'h1);
    chk(q & 32'h4, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 8'h74, 32'h0);
    chk(q & 32'h7, 32'h1);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    chk({16'h0, ee.mem[5]}, 32'h0000_1234);
    // Reads back new and untouched words; clock rate measured
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h70, ctl(1'b0, k ? 7'h7f : 7'h05, 16'h0));
      @(posedge sk);
      t0 = $time;
      @(posedge sk);
      chk(32'(($time - t0) / 64'h8), 32'h100);
      wait_clr(32'h1);
      chk({16'h0, q[31:16]}, k ? 32'h0000_c37f : 32'h0000_1234);
    end
    // Missing acknowledge with the event masked
    bus(1'b1, 8'h78, 32'h0);
    nack <= 1'b1;
    bus(1'b1, 8'h70, ctl(1'b1, 7'h06, 16'h5a5a));
    wait_clr(32'h1);
    chk(q & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h74, 32'h0);
    chk(q & 32'h2, 32'h2);
    wrap_up();
  end
  // About 40k cycles of frames expected; limit leaves some headroom
  initial begin
    #500_000;
    mismatches++;
    wrap_up();
  end
endmodule // eeprom_autoload_access_tb_top
